// ---- bench/dtc_regs_checker.sv ----
/*
  Concurrent checks on the acquisition control register bank ports.
  Assumes one AHB-Lite master with hready tied to hreadyout.
*/
`timescale 1ns/1ns
module dtc_regs_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire dtc_pkg::dtc_ana_in_t ana_in,
  input wire dtc_pkg::dtc_pacer_t pacer_source_select,
  input wire logic convert_pulse,
  input wire logic burst_scan_enable,
  input wire logic pretrigger_enable,
  input wire logic sample_count_start,
  input wire logic user_counter_clock_select,
  input wire dtc_pkg::dtc_cal_out_t cal_out,
  input wire dtc_pkg::dtc_aout_t aout
);
  import dtc_pkg::*;
  // ****************************************
  // data phase tracking and shadow bits
  // ****************************************
  logic dph_ff, wr_ff, mode_ff;
  logic [ADDR_W-1:0] adr_ff;
  logic [15:0] trg_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_ff <= 1'b0;
      wr_ff <= 1'b0;
      adr_ff <= '0;
    end else if (hready) begin
      dph_ff <= hsel && htrans == HTRANS_NONSEQ;
      wr_ff <= hwrite;
      adr_ff <= haddr;
    end
  end
  wire dwr = dph_ff && wr_ff;
  wire drd = dph_ff && !wr_ff;
  wire trg_wr = dwr && adr_ff == ADDR_W'('h10);
  wire cal_wr = dwr && adr_ff == ADDR_W'('h18);
  wire ao_wr = dwr && adr_ff == ADDR_W'('h20);
  wire adc_wr = dwr && adr_ff == ADDR_W'('h28);
  wire dac0_wr = dwr && adr_ff == ADDR_W'('h2C);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trg_ff <= RST_REG16;
      mode_ff <= 1'b0;
    end else begin
      if (trg_wr) trg_ff <= hwdata[15:0];
      if (ao_wr) mode_ff <= hwdata[AO_MODE_BIT];
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_SOFT_CONVERT: assert property (
    adc_wr && pacer_source_select == PACE_SOFT |=> convert_pulse)
    else $error("no conversion after data write");
  AST_EOC_READ: assert property (
    drd && adr_ff == ADDR_W'('h8) && $stable(ana_in.eoc) |-> hrdata[14] == ana_in.eoc)
    else $error("eoc bit wrong");
  AST_BURST: assert property (
    trg_wr |=> burst_scan_enable == $past(hwdata[5]))
    else $error("burst bit wrong");
  AST_PRETRIG: assert property (
    trg_wr |=> pretrigger_enable == $past(hwdata[6]))
    else $error("pretrigger bit wrong");
  AST_CLKSEL: assert property (
    trg_wr |=> user_counter_clock_select == $past(hwdata[13]))
    else $error("counter clock select wrong");
  AST_SCS_OFF: assert property (
    !trg_ff[11] |-> !sample_count_start)
    else $error("counter start without arm");
  AST_SCS_HALF: assert property (
    trg_ff[11] && trg_ff[6] && !trg_ff[12] |->
      sample_count_start == ana_in.fifo_half_full_flag)
    else $error("counter start not half full");
  AST_CAL_SRC: assert property (
    cal_wr |=> cal_out.cal_source_select == $past(hwdata[13:11]) &&
      cal_out.cal_mode_enable == $past(hwdata[14]))
    else $error("cal source wrong");
  AST_TRIM_LOAD: assert property (
    cal_out.trim_dac_load |-> $past(cal_wr) && $past(hwdata[8]))
    else $error("stray trim load");
  AST_POT_LOAD: assert property (
    cal_out.gain_pot_load |-> $past(cal_wr) && $past(hwdata[9]))
    else $error("stray pot load");
  AST_AOUT: assert property (
    ao_wr |=> aout.analog_out_enable == $past(hwdata[1]) &&
      aout.output_range_select0 == $past(hwdata[9:8]) &&
      aout.output_range_select1 == $past(hwdata[11:10]))
    else $error("output control wrong");
  AST_MODE_BOTH: assert property (
    dac0_wr && mode_ff |=> aout.dac1_value == $past(hwdata[11:0]))
    else $error("shared update missing");
  cover property (convert_pulse);
  cover property (cal_out.trim_dac_load);
  cover property (sample_count_start);
endmodule

bind dtc_regs dtc_regs_checker #(.ADDR_W(ADDR_W)) i_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hwdata(hwdata), .hrdata(hrdata), .ana_in(ana_in), .pacer_source_select(pacer_source_select),
  .convert_pulse(convert_pulse), .burst_scan_enable(burst_scan_enable),
  .pretrigger_enable(pretrigger_enable), .sample_count_start(sample_count_start),
  .user_counter_clock_select(user_counter_clock_select), .cal_out(cal_out), .aout(aout));

// ---- bench/testbench.sv ----
/*
  Directed bench for the acquisition control register bank.
  Assumes a zero-wait AHB-Lite slave answering OKAY.
*/
`timescale 1ns/1ns
module testbench;
  import dtc_pkg::*;
  logic hclk = 0, hresetn = 0, hwrite = 0, hreadyout, hresp;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, rd;
  dtc_ana_in_t ana_in = '0;
  logic [3:0] s_lo, s_hi;
  dtc_pacer_t pacer;
  logic conv, run, burst, pre, scs, ucs;
  dtc_cal_out_t cal_out;
  dtc_aout_t aout;
  int n_errors = 0, checks_done = 0, n_conv = 0, n_trim = 0, n_pot = 0;
  logic [10:0] word = 11'h5C5;
  always #4 hclk = ~hclk;
  dtc_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ana_in(ana_in), .scan_start_channel(s_lo),
    .scan_stop_channel(s_hi), .pacer_source_select(pacer), .convert_pulse(conv),
    .paced_run(run), .burst_scan_enable(burst), .pretrigger_enable(pre),
    .sample_count_start(scs), .user_counter_clock_select(ucs), .cal_out(cal_out), .aout(aout));
  // ****************************************
  // pulse counters
  // ****************************************
  // counted mid-cycle so a check at a rising edge never races the count
  always @(negedge hclk) begin
    if (conv === 1'b1) n_conv++;
    if (cal_out.trim_dac_load === 1'b1) n_trim++;
    if (cal_out.gain_pot_load === 1'b1) n_pot++;
  end
  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
    chk(hresp, 32'h0);
  endtask
  task automatic settle();
    @(posedge hclk);
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({aout.analog_out_enable, aout.dac0_value, burst, pre, ucs}, 32'h0);
    rdc(8'h10, 32'h0);
    rdc(8'h3C, 32'h0);
    ana_in.eoc <= 1'b1;
    rdc(8'h08, 32'h4000);
    ana_in.eoc <= 1'b0;
    rdc(8'h08, 32'h0);
    for (int p = 0; p < 4; p++) begin
      wr(8'h08, 32'h21 | (p << 12));
      settle();
      chk({pacer, s_hi, s_lo}, 32'h21 | (p << 8));
    end
    wr(8'h08, 32'h0);
    n_conv = 0;
    wr(8'h28, 32'hFFFF);
    wr(8'h28, 32'h0);
    repeat (2) settle();
    chk(n_conv, 2);
    wr(8'h08, 32'h1000);
    ana_in.timer_pacer <= 1'b1;
    repeat (2) settle();
    ana_in.timer_pacer <= 1'b0;
    repeat (2) settle();
    ana_in.timer_pacer <= 1'b1;
    repeat (2) settle();
    chk(n_conv, 3);
    repeat (PACE_MIN_CYC) settle();
    wr(8'h08, 32'h2000);
    ana_in.ext_pacer <= 1'b1;
    repeat (2) settle();
    chk(n_conv, 3);
    ana_in.ext_pacer <= 1'b0;
    repeat (2) settle();
    chk(n_conv, 4);
    repeat (PACE_MIN_CYC) settle();
    wr(8'h10, 32'h20);
    repeat (PACE_MIN_CYC) settle();
    chk(n_conv, 5);
    repeat (2) settle();
    chk(n_conv, 6);
    wr(8'h10, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h12);
    ana_in.ext_trigger <= 1'b1;
    repeat (2) settle();
    rdc(8'h10, 32'h80);
    chk(run, 1);
    wr(8'h10, 32'h92);
    rdc(8'h10, 32'h0);
    ana_in.ext_trigger <= 1'b0;
    wr(8'h10, 32'h02);
    ana_in.ext_trigger <= 1'b1;
    repeat (2) settle();
    rdc(8'h10, 32'h0);
    ana_in.pre_index_count_done <= 1'b1;
    rdc(8'h10, 32'h1000);
    wr(8'h10, 32'h0840);
    ana_in.fifo_half_full_flag <= 1'b1;
    settle();
    chk(scs, 1);
    wr(8'h10, 32'h1840);
    settle();
    chk(scs, 0);
    wr(8'h10, 32'h2060);
    settle();
    chk({burst, pre, ucs}, 3'b111);
    for (int s = 0; s < 8; s++) begin
      wr(8'h18, 32'h4000 | (s << 11));
      settle();
      chk({cal_out.cal_mode_enable, cal_out.cal_source_select}, 8 | s);
    end
    for (int i = 10; i >= 0; i--) wr(8'h18, 32'h6800 | (word[i] << 15));
    wr(8'h18, 32'h6900);
    settle();
    chk({n_trim, cal_out.trim_dac_channel, cal_out.trim_dac_value}, 32'h5C5 | (1 << 11));
    for (int i = 6; i >= 0; i--) wr(8'h18, 32'h6800 | (word[i] << 15));
    wr(8'h18, 32'h6A00);
    settle();
    chk({n_pot, cal_out.gain_pot_value}, 32'hC5);
    for (int r = 0; r < 4; r++) begin
      wr(8'h20, 32'h2 | (r << 8) | ((3 - r) << 10));
      settle();
      chk({aout.analog_out_enable, aout.output_range_select0, aout.output_range_select1},
        32'h10 | (r << 2) | (3 - r));
    end
    wr(8'h20, 32'h82);
    wr(8'h2C, 32'hABC);
    settle();
    chk({aout.dac0_value, aout.dac1_value}, 32'hABCABC);
    wr(8'h20, 32'h02);
    wr(8'h2C, 32'h123);
    wr(8'h30, 32'h456);
    settle();
    chk({aout.dac0_value, aout.dac1_value}, 32'h123456);
    wrap_up();
  end
endmodule

// ---- core/dtc_pkg.sv ----
/*
  Package for the acquisition control register bank: register indices,
  field positions, reset values, decode enumerations and port carriers.
  Assumes a 32-bit AHB-Lite slave with each register in one aligned word.
*/
package dtc_pkg;

  // ******************************************************************
  // register indices, byte address is four times the index
  // ******************************************************************
  localparam logic [3:0] IDX_ADC_MUX = 4'h2;
  localparam logic [3:0] IDX_TRIG = 4'h4;
  localparam logic [3:0] IDX_CAL = 4'h6;
  localparam logic [3:0] IDX_AOUT = 4'h8;
  localparam logic [3:0] IDX_ADC_DATA = 4'hA;
  localparam logic [3:0] IDX_DAC0_DATA = 4'hB;
  localparam logic [3:0] IDX_DAC1_DATA = 4'hC;
  localparam logic [3:0] IDX_EOC_IN = 4'hD;

  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int ADC_PACER_LSB = 12;
  localparam int ADC_EOC_BIT = 14;
  localparam int TRG_SRC_LSB = 0;
  localparam int TRG_GATE_BIT = 4;
  localparam int TRG_BURST_BIT = 5;
  localparam int TRG_PRE_BIT = 6;
  localparam int TRG_LATCH_BIT = 7;
  localparam int TRG_ARM_BIT = 11;
  localparam int TRG_FFM_BIT = 12;
  localparam int TRG_INDEX_BIT = 12;
  localparam int TRG_CLKSEL_BIT = 13;
  localparam int CAL_TRIM_BIT = 8;
  localparam int CAL_POT_BIT = 9;
  localparam int CAL_SRC_LSB = 11;
  localparam int CAL_EN_BIT = 14;
  localparam int CAL_SDI_BIT = 15;
  localparam int AO_EN_BIT = 1;
  localparam int AO_MODE_BIT = 7;
  localparam int AO_R0_LSB = 8;
  localparam int AO_R1_LSB = 10;

  // ******************************************************************
  // reset values and sizes
  // ******************************************************************
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam int POT_BITS = 7;
  localparam int TRIM_BITS = 11;
  localparam int DAC_BITS = 12;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // fastest paced rate, kHz, and the matching least spacing in cycles
  localparam int CLK_KHZ = 125000;
  localparam int PACE_MAX_KHZ = 330;
  localparam int PACE_MIN_CYC = (CLK_KHZ + PACE_MAX_KHZ - 1) / PACE_MAX_KHZ;

  typedef enum logic [1:0] {
    PACE_SOFT = 2'b00,
    PACE_TIMER = 2'b01,
    PACE_EXT_FALL = 2'b10,
    PACE_EXT_RISE = 2'b11
  } dtc_pacer_t;

  typedef enum logic [1:0] {
    TRG_OFF = 2'b00,
    TRG_SOFT = 2'b01,
    TRG_EXT = 2'b10,
    TRG_UNDEF = 2'b11
  } dtc_trig_t;

  // analog side inputs
  typedef struct packed {
    logic eoc;
    logic timer_pacer;
    logic ext_pacer;
    logic ext_trigger;
    logic fifo_half_full_flag;
    logic pre_index_count_done;
  } dtc_ana_in_t;

  // calibration controls
  typedef struct packed {
    logic cal_mode_enable;
    logic [2:0] cal_source_select;
    logic [7:0] trim_dac_value;
    logic [2:0] trim_dac_channel;
    logic trim_dac_load;
    logic [POT_BITS-1:0] gain_pot_value;
    logic gain_pot_load;
  } dtc_cal_out_t;

  // analog output controls
  typedef struct packed {
    logic analog_out_enable;
    logic [1:0] output_range_select0;
    logic [1:0] output_range_select1;
    logic [DAC_BITS-1:0] dac0_value;
    logic [DAC_BITS-1:0] dac1_value;
  } dtc_aout_t;

endpackage

// ---- core/dtc_regs.sv ----
/*
  Acquisition control register bank: pacer and trigger control, external
  trigger latch, sample-counter start select, serial calibration shifter,
  analog output control. Assumes a single AHB-Lite master on hclk and
  analog-side signals already synchronous to hclk.
*/
`timescale 1ns/1ns
module dtc_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire dtc_pkg::dtc_ana_in_t ana_in,
  output logic [3:0] scan_start_channel,
  output logic [3:0] scan_stop_channel,
  output dtc_pkg::dtc_pacer_t pacer_source_select,
  output logic convert_pulse,
  output logic paced_run,
  output logic burst_scan_enable,
  output logic pretrigger_enable,
  output logic sample_count_start,
  output logic user_counter_clock_select,
  output dtc_pkg::dtc_cal_out_t cal_out,
  output dtc_pkg::dtc_aout_t aout
);
  import dtc_pkg::*;

  // ******************************************************************
  // bus slave: capture address phase, act in data phase
  // ******************************************************************
  logic wr_ph_ff;
  logic [3:0] idx_ff;
  logic [15:0] mux_ff;
  logic [15:0] trig_ff;
  logic [15:0] cal_ff;
  logic [15:0] aout_ff;
  logic latch_ff;
  logic ext_trig_prev_ff;
  logic ext_pace_prev_ff;
  logic timer_prev_ff;
  logic [TRIM_BITS-1:0] shift_ff;
  logic [8:0] pace_cnt_ff;
  logic [31:0] hrdata_ff;
  logic conv_ff;
  logic eoc_in_ff;
  logic [DAC_BITS-1:0] dac0_ff;
  logic [DAC_BITS-1:0] dac1_ff;
  logic trim_load_ff;
  logic pot_load_ff;
  logic addr_ok;
  logic take;
  logic wr;
  logic rd_ok;
  logic [15:0] wd;
  logic ext_rise;
  logic pace_evt;
  logic pace_raw;
  logic cal_wr;
  dtc_trig_t tsrc;

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_ok = (haddr[1:0] == 2'b00) && (haddr[ADDR_W-1:6] == '0) &&
                   (hsize == HSIZE_WORD);
  assign wr = wr_ph_ff;
  assign wd = hwdata[15:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_ff <= 1'b0;
      idx_ff <= 4'h0;
    end else begin
      wr_ph_ff <= take && hwrite && addr_ok;
      idx_ff <= haddr[5:2];
    end
  end

  // read data is registered in the address phase so it stands in the data phase
  always_comb begin
    rd_ok = take && !hwrite && addr_ok;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_ok) begin
      unique case (haddr[5:2])
        IDX_ADC_MUX: begin
          hrdata_ff <= '0;
          hrdata_ff[ADC_EOC_BIT] <= ana_in.eoc;
        end
        IDX_TRIG: begin
          hrdata_ff <= '0;
          hrdata_ff[TRG_LATCH_BIT] <= latch_ff;
          hrdata_ff[TRG_INDEX_BIT] <= ana_in.pre_index_count_done;
        end
        IDX_EOC_IN: hrdata_ff <= {31'h0000_0000, eoc_in_ff};
        default: hrdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      hrdata_ff <= 32'h0000_0000;
    end
  end

  // ******************************************************************
  // control registers
  // ******************************************************************
  assign cal_wr = wr && (idx_ff == IDX_CAL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mux_ff <= RST_REG16;
      trig_ff <= RST_REG16;
      cal_ff <= RST_REG16;
      aout_ff <= RST_REG16;
    end else if (wr) begin
      if (idx_ff == IDX_ADC_MUX) begin
        mux_ff <= wd;
      end
      if (idx_ff == IDX_TRIG) begin
        trig_ff <= wd;
        trig_ff[TRG_LATCH_BIT] <= 1'b0;
      end
      if (cal_wr) begin
        cal_ff <= wd;
      end
      if (idx_ff == IDX_AOUT) begin
        aout_ff <= wd;
      end
    end
  end

  assign scan_start_channel = mux_ff[3:0];
  assign scan_stop_channel = mux_ff[7:4];
  assign pacer_source_select = dtc_pacer_t'(mux_ff[ADC_PACER_LSB +: 2]);
  assign tsrc = dtc_trig_t'(trig_ff[TRG_SRC_LSB +: 2]);
  assign burst_scan_enable = trig_ff[TRG_BURST_BIT];
  assign pretrigger_enable = trig_ff[TRG_PRE_BIT];
  assign user_counter_clock_select = trig_ff[TRG_CLKSEL_BIT];

  // ******************************************************************
  // external trigger latch; set wins over a same-cycle clear only while the latch is clear, otherwise the clear wins
  // ******************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_trig_prev_ff <= 1'b0;
    end else begin
      ext_trig_prev_ff <= ana_in.ext_trigger;
    end
  end

  assign ext_rise = ana_in.ext_trigger && !ext_trig_prev_ff && trig_ff[TRG_GATE_BIT]
                    && (tsrc == TRG_EXT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_ff <= 1'b0;
    end else if (ext_rise && !latch_ff) begin
      latch_ff <= 1'b1;
    end else if (wr && idx_ff == IDX_TRIG && wd[TRG_LATCH_BIT]) begin
      latch_ff <= 1'b0;
    end
  end

  // ******************************************************************
  // pacing and conversion start
  // ******************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_pace_prev_ff <= 1'b0;
      timer_prev_ff <= 1'b0;
    end else begin
      ext_pace_prev_ff <= ana_in.ext_pacer;
      timer_prev_ff <= ana_in.timer_pacer;
    end
  end

  // trigger off runs freely; software trigger runs at once; external waits for latch
  assign paced_run = (tsrc == TRG_OFF) || (tsrc == TRG_SOFT) ||
                     ((tsrc == TRG_EXT) && latch_ff);

  always_comb begin
    unique case (pacer_source_select)
      PACE_SOFT: pace_raw = 1'b0;
      PACE_TIMER: pace_raw = ana_in.timer_pacer && !timer_prev_ff;
      PACE_EXT_FALL: pace_raw = !ana_in.ext_pacer && ext_pace_prev_ff;
      PACE_EXT_RISE: pace_raw = ana_in.ext_pacer && !ext_pace_prev_ff;
    endcase
  end

  // paced or burst conversions never come closer than the 330 kHz spacing
  assign pace_evt = (pace_cnt_ff == 9'h000) &&
                    ((pace_raw && paced_run) || (burst_scan_enable && paced_run &&
                     pacer_source_select != PACE_SOFT));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pace_cnt_ff <= 9'h000;
    end else if (pace_evt) begin
      pace_cnt_ff <= 9'(PACE_MIN_CYC - 1);
    end else if (pace_cnt_ff != 9'h000) begin
      pace_cnt_ff <= pace_cnt_ff - 9'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_ff <= 1'b0;
      eoc_in_ff <= 1'b0;
    end else begin
      conv_ff <= pace_evt || (wr && idx_ff == IDX_ADC_DATA &&
                 pacer_source_select == PACE_SOFT);
      eoc_in_ff <= ana_in.eoc;
    end
  end
  assign convert_pulse = conv_ff;

  // ******************************************************************
  // sample counter start select
  // ******************************************************************
  always_comb begin
    if (!trig_ff[TRG_ARM_BIT]) begin
      sample_count_start = 1'b0;
    end else if (!pretrigger_enable) begin
      sample_count_start = conv_ff;
    end else if (!trig_ff[TRG_FFM_BIT]) begin
      sample_count_start = ana_in.fifo_half_full_flag;
    end else begin
      sample_count_start = latch_ff;
    end
  end

  // ******************************************************************
  // serial calibration shifter, one bit per write with both load bits clear, MSB first
  // ******************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_ff <= '0;
      trim_load_ff <= 1'b0;
      pot_load_ff <= 1'b0;
    end else begin
      trim_load_ff <= cal_wr && wd[CAL_TRIM_BIT] && !cal_ff[CAL_TRIM_BIT];
      pot_load_ff <= cal_wr && wd[CAL_POT_BIT] && !cal_ff[CAL_POT_BIT];
      if (cal_wr && !wd[CAL_TRIM_BIT] && !wd[CAL_POT_BIT]) begin
        shift_ff <= {shift_ff[TRIM_BITS-2:0], wd[CAL_SDI_BIT]};
      end
    end
  end

  // trim word is three address bits then eight data bits
  assign cal_out.trim_dac_channel = shift_ff[10:8];
  assign cal_out.trim_dac_value = shift_ff[7:0];
  assign cal_out.trim_dac_load = trim_load_ff;
  assign cal_out.gain_pot_value = shift_ff[POT_BITS-1:0];
  assign cal_out.gain_pot_load = pot_load_ff;
  assign cal_out.cal_source_select = cal_ff[CAL_SRC_LSB +: 3];
  assign cal_out.cal_mode_enable = cal_ff[CAL_EN_BIT];

  // ******************************************************************
  // analog output data and control
  // ******************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac0_ff <= '0;
      dac1_ff <= '0;
    end else if (wr) begin
      if (idx_ff == IDX_DAC0_DATA) begin
        dac0_ff <= hwdata[DAC_BITS-1:0];
        if (aout_ff[AO_MODE_BIT]) begin
          dac1_ff <= hwdata[DAC_BITS-1:0];
        end
      end
      if (idx_ff == IDX_DAC1_DATA) begin
        dac1_ff <= hwdata[DAC_BITS-1:0];
      end
    end
  end

  assign aout.analog_out_enable = aout_ff[AO_EN_BIT];
  assign aout.output_range_select0 = aout_ff[AO_R0_LSB +: 2];
  assign aout.output_range_select1 = aout_ff[AO_R1_LSB +: 2];
  assign aout.dac0_value = dac0_ff;
  assign aout.dac1_value = dac1_ff;

endmodule
